//--- hw/ovu_top.sv
`timescale 1ns/1ps
`default_nettype none
module ovu_top
  import ovu_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = OVU_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [8:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic [8:0]      reg_rdata_o,
  // Signal sign per channel, order phones L/R, line L/R, speaker L/R
  input  wire logic [5:0] chan_sign_i,
  input  wire logic [5:0] chan_sample_i,
  // Applied gains to the drivers
  output logic [5:0]      phones_left_pin_level_o,
  output logic [5:0]      phones_right_pin_level_o,
  output logic [5:0]      lineport_left_pin_level_o,
  output logic [5:0]      lineport_right_pin_level_o,
  output logic [5:0]      diff_left_pins_level_o,
  output logic [5:0]      diff_right_pins_level_o,
  output logic [5:0]      chan_silence_o
);

  // ==========================================================================
  // Register index decode.
  function automatic logic [2:0] chan_index(input logic [7:0] addr);
    unique case (addr)
      OVU_ADDR_PHONES_LEFT:    chan_index = 3'd0;
      OVU_ADDR_PHONES_RIGHT:   chan_index = 3'd1;
      OVU_ADDR_LINEPORT_LEFT:  chan_index = 3'd2;
      OVU_ADDR_LINEPORT_RIGHT: chan_index = 3'd3;
      OVU_ADDR_DIFF_LEFT:      chan_index = 3'd4;
      OVU_ADDR_DIFF_RIGHT:     chan_index = 3'd5;
      default:                 chan_index = 3'd7;
    endcase
  endfunction : chan_index

  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic       wr_hit;

  assign wr_idx = chan_index(reg_addr_i);
  assign rd_idx = wr_idx;
  assign wr_hit = reg_wr_i && (wr_idx != 3'd7);

  // ==========================================================================
  // Stored level, mute and zero-cross fields, one set per channel.
  logic [5:0] level_store [OVU_NUM_CHAN];
  logic [5:0] silence;
  logic [5:0] gate;
  logic       crossing_timeout_enable;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_store[0] <= OVU_LEVEL_PHONES_RST;
      level_store[1] <= OVU_LEVEL_PHONES_RST;
      level_store[2] <= OVU_LEVEL_ZERO_DB;
      level_store[3] <= OVU_LEVEL_ZERO_DB;
      level_store[4] <= OVU_LEVEL_ZERO_DB;
      level_store[5] <= OVU_LEVEL_ZERO_DB;
    end else if (wr_hit) begin
      level_store[wr_idx] <= reg_wdata_i[OVU_LEVEL_MSB:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      silence <= OVU_SILENCE_RST;
      gate    <= 6'h0;
    end else if (wr_hit) begin
      silence[wr_idx] <= reg_wdata_i[OVU_SILENCE_BIT];
      gate[wr_idx]    <= reg_wdata_i[OVU_GATE_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crossing_timeout_enable <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == OVU_ADDR_TIMEOUT_CTRL) begin
      crossing_timeout_enable <= reg_wdata_i[0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_silence_o <= OVU_SILENCE_RST;
    end else begin
      chan_silence_o <= silence;
    end
  end

  // ==========================================================================
  // Pair apply triggers; the level written in the same cycle is taken too.
  logic [2:0] pair_apply;
  logic [5:0] chan_apply;
  logic [5:0] staged [OVU_NUM_CHAN];
  logic [5:0] next_gate;

  always_comb begin
    pair_apply = 3'h0;
    if (wr_hit && reg_wdata_i[OVU_APPLY_BIT]) begin
      pair_apply[wr_idx[2:1]] = 1'b1;
    end
    chan_apply = {{2{pair_apply[2]}}, {2{pair_apply[1]}}, {2{pair_apply[0]}}};
  end

  always_comb begin
    next_gate = gate;
    for (int i = 0; i < OVU_NUM_CHAN; i++) begin
      staged[i] = level_store[i];
    end
    if (wr_hit) begin
      staged[wr_idx]    = reg_wdata_i[OVU_LEVEL_MSB:0];
      next_gate[wr_idx] = reg_wdata_i[OVU_GATE_BIT];
    end
  end

  // ==========================================================================
  // Sign inputs come from another domain and are synchronised.
  logic [5:0] sign_meta;
  logic [5:0] sign_sync;
  logic [5:0] smp_meta;
  logic [5:0] smp_sync;
  logic [5:0] smp_prev;
  logic [5:0] smp_pulse;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sign_meta <= 6'h0;
      sign_sync <= 6'h0;
      smp_meta  <= 6'h0;
      smp_sync  <= 6'h0;
      smp_prev  <= 6'h0;
    end else begin
      sign_meta <= chan_sign_i;
      sign_sync <= sign_meta;
      smp_meta  <= chan_sample_i;
      smp_sync  <= smp_meta;
      smp_prev  <= smp_sync;
    end
  end

  assign smp_pulse = smp_sync & ~smp_prev;

  // ==========================================================================
  // One gated apply unit per channel.
  logic [5:0] applied [OVU_NUM_CHAN];
  logic [5:0] pending;

  for (genvar g = 0; g < OVU_NUM_CHAN; g++) begin : g_chan
    ovu_channel #(
      .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) u_chan (
      .sys_clk_i    (sys_clk_i),
      .nrst_i       (nrst_i),
      .apply_i      (chan_apply[g]),
      .staged_i     (staged[g]),
      .gate_i       (next_gate[g]),
      .timeout_en_i (crossing_timeout_enable),
      .sign_i       (sign_sync[g]),
      .sample_i     (smp_pulse[g]),
      .level_o      (applied[g]),
      .pending_o    (pending[g])
    );
  end

  assign phones_left_pin_level_o    = applied[0];
  assign phones_right_pin_level_o   = applied[1];
  assign lineport_left_pin_level_o  = applied[2];
  assign lineport_right_pin_level_o = applied[3];
  assign diff_left_pins_level_o     = applied[4];
  assign diff_right_pins_level_o    = applied[5];

  // ==========================================================================
  // Read data, valid the cycle after the read strobe.
  logic [8:0] next_rdata;

  always_comb begin
    next_rdata = 9'h0;
    if (rd_idx != 3'd7) begin
      next_rdata = {silence[rd_idx], 1'b0, gate[rd_idx], level_store[rd_idx]};
    end else if (reg_addr_i == OVU_ADDR_TIMEOUT_CTRL) begin
      next_rdata = {8'h0, crossing_timeout_enable};
    end else if (reg_addr_i == OVU_ADDR_PENDING_STAT) begin
      next_rdata = {3'h0, pending};
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 9'h0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 9'h0;
    end
  end

endmodule : ovu_top
`default_nettype wire

//--- hw/ovu_pkg.sv
package ovu_pkg;

  // ==========================================================================
  // Register map (byte offsets on the control port).
  localparam logic [7:0] OVU_ADDR_PHONES_LEFT   = 8'h39;
  localparam logic [7:0] OVU_ADDR_PHONES_RIGHT  = 8'h3a;
  localparam logic [7:0] OVU_ADDR_LINEPORT_LEFT = 8'h3b;
  localparam logic [7:0] OVU_ADDR_LINEPORT_RIGHT = 8'h3c;
  localparam logic [7:0] OVU_ADDR_DIFF_LEFT     = 8'h3e;
  localparam logic [7:0] OVU_ADDR_DIFF_RIGHT    = 8'h3f;
  localparam logic [7:0] OVU_ADDR_TIMEOUT_CTRL  = 8'h40;
  localparam logic [7:0] OVU_ADDR_PENDING_STAT  = 8'h41;

  // ==========================================================================
  // Field positions inside each gain register.
  localparam int OVU_SILENCE_BIT = 8;
  localparam int OVU_APPLY_BIT   = 7;
  localparam int OVU_GATE_BIT    = 6;
  localparam int OVU_LEVEL_MSB   = 5;
  localparam int OVU_NUM_CHAN    = 6;

  // ==========================================================================
  // Reset values and gain mapping.
  localparam logic [5:0] OVU_LEVEL_PHONES_RST = 6'h2d;
  localparam logic [5:0] OVU_LEVEL_ZERO_DB    = 6'h39;
  localparam logic [5:0] OVU_SILENCE_RST      = 6'h30;
  localparam logic signed [7:0] OVU_GAIN_MIN_DB = -8'sd57;

  // ==========================================================================
  // Timeout for a gated update with no crossing.
  localparam int OVU_TIMEOUT_US     = 100;
  localparam int OVU_CLK_MHZ        = 125;
  localparam int OVU_TIMEOUT_CYCLES = OVU_TIMEOUT_US * OVU_CLK_MHZ;

  // Gain in dB of a level code, 1 dB per step from -57 dB.
  function automatic logic signed [7:0] ovu_gain_db(input logic [5:0] code);
    ovu_gain_db = OVU_GAIN_MIN_DB + $signed({2'b00, code});
  endfunction : ovu_gain_db

endpackage : ovu_pkg

//--- hw/ovu_channel.sv
`timescale 1ns/1ps
`default_nettype none
module ovu_channel
  import ovu_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = OVU_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // Control
  input  wire logic       apply_i,
  input  wire logic [5:0] staged_i,
  input  wire logic       gate_i,
  input  wire logic       timeout_en_i,
  input  wire logic       sign_i,
  input  wire logic       sample_i,
  // Result
  output logic [5:0]      level_o,
  output logic            pending_o
);

  // ==========================================================================
  // Crossing detection and timeout.
  logic        last_sign;
  logic        crossing;
  logic [31:0] wait_cnt;
  logic        timed_out;

  assign crossing  = sample_i && (sign_i != last_sign);
  assign timed_out = timeout_en_i && (wait_cnt >= 32'(TIMEOUT_CYCLES - 1));

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_sign <= 1'b0;
    end else if (sample_i) begin
      last_sign <= sign_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_cnt <= 32'h0;
    end else if (!pending_o || apply_i || !timeout_en_i) begin
      wait_cnt <= 32'h0;
    end else begin
      wait_cnt <= wait_cnt + 32'h1;
    end
  end

  // ==========================================================================
  // Applied level, gated independently per channel.
  logic [5:0] held;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_o   <= 6'h0;
      held      <= 6'h0;
      pending_o <= 1'b0;
    end else if (apply_i && !gate_i) begin
      level_o   <= staged_i;
      pending_o <= 1'b0;
    end else if (apply_i) begin
      held      <= staged_i;
      pending_o <= 1'b1;
    end else if (pending_o && (crossing || timed_out)) begin
      level_o   <= held;
      pending_o <= 1'b0;
    end
  end

endmodule : ovu_channel
`default_nettype wire

//--- sim/ovu_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ovu_top_chk
  import ovu_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = OVU_TIMEOUT_CYCLES
) (
  // Clock, reset and register port
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [8:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [8:0] reg_rdata_o,
  // Applied levels and mutes
  input wire logic [5:0] phones_left_pin_level_o,
  input wire logic [5:0] phones_right_pin_level_o,
  input wire logic [5:0] lineport_left_pin_level_o,
  input wire logic [5:0] diff_right_pins_level_o,
  input wire logic [5:0] chan_silence_o
);
  logic [8:0] last_wd;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // Last written data, so a check may look one or two edges past the write.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) last_wd <= 9'h000;
    else if (reg_wr_i) last_wd <= reg_wdata_i;
  end

  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 9'h000)
    else $error("read data not zero outside read answer");
  chk_apply_reads_zero: assert property ($past(reg_rd_i) |-> !reg_rdata_o[7])
    else $error("apply bit read back as one");
  chk_phones_left_apply: assert property (
    reg_wr_i && reg_addr_i == 8'h39 && reg_wdata_i[7:6] == 2'b10
    |-> ##[1:2] phones_left_pin_level_o == last_wd[5:0])
    else $error("phones left level not applied");
  chk_phones_right_apply: assert property (
    reg_wr_i && reg_addr_i == 8'h3a && reg_wdata_i[7:6] == 2'b10
    |-> ##[1:2] phones_right_pin_level_o == last_wd[5:0])
    else $error("phones right level not applied");
  chk_line_apply: assert property (
    reg_wr_i && reg_addr_i == 8'h3b && reg_wdata_i[7:6] == 2'b10
    |-> ##[1:2] lineport_left_pin_level_o == last_wd[5:0])
    else $error("line left level not applied");
  chk_diff_apply: assert property (
    reg_wr_i && reg_addr_i == 8'h3f && reg_wdata_i[7:6] == 2'b10
    |-> ##[1:2] diff_right_pins_level_o == last_wd[5:0])
    else $error("speaker right level not applied");
  chk_mute_follow: assert property (
    reg_wr_i && reg_addr_i == 8'h39 |-> ##[1:2] chan_silence_o[0] == last_wd[8])
    else $error("phones left mute not following register");
  chk_diff_mute_follow: assert property (
    reg_wr_i && reg_addr_i == 8'h3f |-> ##[1:2] chan_silence_o[5] == last_wd[8])
    else $error("speaker right mute not following register");

  cover property (reg_wr_i && reg_wdata_i[7]);
  cover property ($changed(lineport_left_pin_level_o));
  cover property (reg_rd_i && reg_addr_i == 8'h41);
endmodule : ovu_top_chk
`default_nettype wire

//--- sim/ovu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module ovu_top_tb;
  import ovu_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic [7:0]  addr      = 8'h00;
  logic [8:0]  wdata     = 9'h000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [5:0]  sign      = 6'h00;
  logic [5:0]  smp       = 6'h00;
  logic [8:0]  rdata;
  wire  [35:0] lv;
  logic [5:0]  sil;
  logic [5:0]  exp_lv [6] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
  logic [5:0]  exp_sil   = 6'h30;
  logic [8:0]  rst_val [6] = '{9'h02d, 9'h02d, 9'h039, 9'h039, 9'h139, 9'h139};
  logic [7:0]  regs [6]    = '{8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3e, 8'h3f};
  int          bad_count    = 0;
  int          total_checks = 0;
  int          n;
  int          s;

  always #4 sys_clk_i = ~sys_clk_i;

  ovu_top #(.TIMEOUT_CYCLES(16)) i_dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .chan_sign_i(sign),
    .chan_sample_i(smp), .phones_left_pin_level_o(lv[5:0]),
    .phones_right_pin_level_o(lv[11:6]), .lineport_left_pin_level_o(lv[17:12]),
    .lineport_right_pin_level_o(lv[23:18]), .diff_left_pins_level_o(lv[29:24]),
    .diff_right_pins_level_o(lv[35:30]), .chan_silence_o(sil));

  // ====
  // Bus and comparison tasks.
  task automatic wr_reg(input logic [7:0] a, input logic [8:0] d);
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [8:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd_reg

  task automatic chk_out();
    repeat (3) @(posedge sys_clk_i);
    #1;
    for (int i = 0; i < 6; i++) `CHK("level", exp_lv[i], lv[6*i+:6])
    `CHK("silence", exp_sil, sil)
  endtask : chk_out

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // ====
  // Main sequence.
  initial begin
    repeat (12) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    chk_out();
    `CHK("gain min", 8'hc7, ovu_gain_db(6'h00))
    `CHK("gain zero", 8'h00, ovu_gain_db(6'h39))
    `CHK("gain max", 8'h06, ovu_gain_db(6'h3f))
    for (int i = 0; i < 6; i++) rd_reg(regs[i], rst_val[i]);
    wr_reg(8'h3d, 9'h1ff);
    rd_reg(8'h3d, 9'h000);
    // Stage one side of each pair, then apply from the other side.
    for (int p = 0; p < 3; p++) begin
      s = p % 2;
      wr_reg(regs[2*p+s], 9'h015);
      exp_sil[2*p+s] = 1'b0;
      chk_out();
      wr_reg(regs[2*p+1-s], 9'h0bf);
      exp_lv[2*p+s]   = 6'h15;
      exp_lv[2*p+1-s] = 6'h3f;
      exp_sil[2*p+1-s] = 1'b0;
      chk_out();
    end
    wr_reg(8'h39, 9'h187);
    exp_lv[0]  = 6'h07;
    exp_sil[0] = 1'b1;
    chk_out();
    rd_reg(8'h39, 9'h107);
    // Gated apply on the line pair, crossing on the left only.
    wr_reg(8'h3b, 9'h04a);
    wr_reg(8'h3c, 9'h0ea);
    repeat (20) @(posedge sys_clk_i);
    chk_out();
    @(posedge sys_clk_i);
    sign <= 6'h04;
    smp  <= 6'h04;
    repeat (2) @(posedge sys_clk_i);
    smp <= 6'h00;
    exp_lv[2] = 6'h0a;
    chk_out();
    rd_reg(8'h41, 9'h008);
    wr_reg(8'h40, 9'h001);
    for (n = 0; n < 100 && lv[23:18] !== 6'h2a; n++) @(posedge sys_clk_i);
    if (n == 100) begin
      bad_count++;
      $display("[ERR] timeout apply exp %h got %h", 6'h2a, lv[23:18]);
    end else begin
      `CHK("timeout wait", 17, n)
      exp_lv[3] = 6'h2a;
      chk_out();
      rd_reg(8'h41, 9'h000);
      // Gated speaker pair, released by the timeout alone.
      wr_reg(8'h3e, 9'h040);
      wr_reg(8'h3f, 9'h0c5);
      chk_out();
      rd_reg(8'h41, 9'h030);
      repeat (20) @(posedge sys_clk_i);
      exp_lv[4] = 6'h00;
      exp_lv[5] = 6'h05;
      chk_out();
    end
    conclude();
  end
endmodule : ovu_top_tb

bind ovu_top ovu_top_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .phones_left_pin_level_o(phones_left_pin_level_o),
  .phones_right_pin_level_o(phones_right_pin_level_o),
  .lineport_left_pin_level_o(lineport_left_pin_level_o),
  .diff_right_pins_level_o(diff_right_pins_level_o), .chan_silence_o(chan_silence_o));
`default_nettype wire
